//--- src/smi_top.sv
// Purpose: two-wire serial interface, master and slave, byte-wise engine
// Assumes: open-drain pads outside; timer overflows are mclk pulses
// Notes: SCL is held low while a byte, an ack or queue room is awaited
//
// Contract
// - bytes shift autonomously; bit rate never above mclk over twenty
// - master, slave or both; works with other masters on the bus
// - software ack mode or hardware address match with automatic ack
// - first byte after START is seven-bit address then direction bit
// - direction one means read, zero means write
// - ack is SDA low in ack slot; SDA high there is nack
// - master sends START, address, data, then STOP; master makes SCL
// - write: slave acks each byte; read: master acks each byte, but with hardware ack it nacks the byte received while a stop is pending
// - transmitter drives eight bits, receiver drives the ack slot
// - master starts only on free bus: after STOP or free timeout
// - master seeing low SDA when releasing it loses; becomes slave only if it loses in the address phase
// - master waits for SCL actually high before timing high phase
// - SCL low over 25 ms is timeout; reset link within 10 ms
// - with low timeout enabled timer reloads high, counts low
// - with free timeout enabled, bus free after more than ten source periods high
// - pending master START goes out when free timeout expires
// - free timeout needs running clock source even as slave only
// - byte event after ack when sending, before when receiving in software mode
// - clock source select 00 t0, 01 t1, 10 t2 high, 11 t2 low
// - master SCL low at least one source tick, high at least two source ticks
`timescale 1ns/10ps
module smi_top #(
    parameter int LOW_TO_CYC = smi_pkg::LOW_TIMEOUT_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic enable,
    input wire logic slave_inhibit,
    input wire logic hw_ack_enable,
    input wire logic [1:0] bit_clock_source_select,
    input wire logic scl_low_timeout_enable,
    input wire logic bus_free_timeout_enable,
    input wire logic [6:0] own_addr,
    input wire logic [3:0] timer_ovf,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_n,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic start_req,
    input wire logic stop_req,
    input wire logic [smi_pkg::DATA_W-1:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic sw_ack_valid,
    input wire logic sw_ack_value,
    output logic [smi_pkg::DATA_W-1:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic byte_event,
    output logic start_event,
    output logic stop_event,
    output logic arb_lost,
    output logic got_ack,
    output logic [smi_pkg::DATA_W-1:0] addr_byte,
    output logic is_master,
    output logic is_slave,
    output logic bus_busy,
    output logic scl_timer_reload,
    output logic scl_low_timeout
);
    import smi_pkg::*;
    smi_mon_if mon_if ();
    smi_mst_e mst_reg;
    smi_mst_e mst_next;
    logic [3:0] cyc_cnt_reg;
    logic [1:0] tk_cnt_reg;
    logic [3:0] slot_reg;
    logic [7:0] shift_reg;
    logic [7:0] rx_byte_reg;
    logic [7:0] addr_reg;
    logic master_reg, slave_act_reg, pre_reg, addr_phase_reg, dir_reg, inh_reg;
    logic sda_low_reg, ack_bit_reg, got_ack_reg, need_tx_reg, need_ack_reg;
    logic push_pend_reg, start_pend_reg, stop_pend_reg, stop_go_reg;
    logic byte_ev_reg, start_ev_reg, stop_ev_reg, lost_ev_reg;
    logic scl_pin_low_reg, sda_pin_low_reg;
    logic active, tx_mode, hold, lost_c, is_mst, match, tx_take, ack_take;
    logic timer_done, sda_force, sess_clr, rise, fall, fifo_ready;
    logic [1:0] tk_need;
    logic [7:0] byte_in;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    assign active = master_reg || slave_act_reg;
    assign tx_mode = addr_phase_reg ? master_reg : (master_reg ^ dir_reg);
    assign byte_in = {shift_reg[6:0], mon_if.sda};
    assign match = byte_in[7:1] == own_addr;
    assign hold = active && (need_tx_reg || need_ack_reg || push_pend_reg);
    assign tx_take = need_tx_reg && tx_valid;
    assign ack_take = need_ack_reg && sw_ack_valid && slot_reg == ACK_SLOT;
    assign rise = mon_if.scl_rise && active && !pre_reg;
    assign fall = mon_if.scl_fall && active;
    assign lost_c = rise && master_reg && tx_mode && slot_reg < ACK_SLOT
        && !sda_low_reg && !mon_if.sda && !sda_force;
    assign is_mst = master_reg && !lost_c;
    assign sess_clr = !enable || mon_if.low_timeout || mon_if.stop_det;
    assign sda_force = mst_reg == M_START || mst_reg == M_STOP || mst_reg == M_STOPH
        || (mst_reg == M_LOW && (pre_reg || stop_go_reg));
    assign tk_need = (mst_reg == M_LOW) ? LOW_TICKS : HIGH_TICKS;
    assign timer_done = cyc_cnt_reg == MIN_HALF_CYC && tk_cnt_reg >= tk_need;

    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe_n = !scl_pin_low_reg;
    assign sda_oe_n = !sda_pin_low_reg;
    assign tx_ready = need_tx_reg;
    assign byte_event = byte_ev_reg;
    assign start_event = start_ev_reg;
    assign stop_event = stop_ev_reg;
    assign arb_lost = lost_ev_reg;
    assign got_ack = got_ack_reg;
    assign addr_byte = addr_reg;
    assign is_master = master_reg;
    assign is_slave = slave_act_reg;
    assign bus_busy = !mon_if.bus_free;

    // ----------------------------------------------------------------
    // master clock generator
    // ----------------------------------------------------------------
    always_comb begin
        mst_next = mst_reg;
        case (mst_reg)
            M_IDLE: if (start_pend_reg && mon_if.bus_free && mon_if.scl && mon_if.sda) begin
                mst_next = M_START;
            end
            M_START: if (timer_done) begin
                mst_next = M_LOW;
            end
            M_LOW: if (timer_done && !hold) begin
                mst_next = stop_go_reg ? M_STOP : M_RISE;
            end
            M_RISE: if (mon_if.scl) begin
                mst_next = M_HIGH;
            end
            M_HIGH: if (timer_done || !mon_if.scl) begin
                mst_next = M_LOW;
            end
            M_STOP: if (mon_if.scl) begin
                mst_next = M_STOPH;
            end
            M_STOPH: if (timer_done) begin
                mst_next = M_IDLE;
            end
            default: mst_next = M_IDLE;
        endcase
        if (!master_reg && mst_reg != M_IDLE && mst_reg != M_START) begin
            mst_next = M_IDLE;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || !enable || mon_if.low_timeout) begin
            mst_reg <= M_IDLE;
        end else begin
            mst_reg <= mst_next;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || mst_next != mst_reg || mst_reg == M_RISE || mst_reg == M_STOP) begin
            cyc_cnt_reg <= 4'h0;
            tk_cnt_reg <= 2'h0;
        end else begin
            if (cyc_cnt_reg != MIN_HALF_CYC) begin
                cyc_cnt_reg <= cyc_cnt_reg + 4'h1;
            end
            if (mon_if.tick && tk_cnt_reg != HIGH_TICKS) begin
                tk_cnt_reg <= tk_cnt_reg + 2'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // byte engine, shared by master and slave roles
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        byte_ev_reg <= 1'b0;
        start_ev_reg <= 1'b0;
        stop_ev_reg <= 1'b0;
        lost_ev_reg <= 1'b0;
        if (rst || sess_clr) begin
            master_reg <= 1'b0;
            slave_act_reg <= 1'b0;
            pre_reg <= 1'b0;
            addr_phase_reg <= 1'b0;
            sda_low_reg <= 1'b0;
            need_tx_reg <= 1'b0;
            need_ack_reg <= 1'b0;
            stop_go_reg <= 1'b0;
            slot_reg <= ACK_SLOT;
            stop_ev_reg <= !rst && mon_if.stop_det;
        end else if (mon_if.start_det) begin
            master_reg <= mst_reg == M_START;
            slave_act_reg <= mst_reg != M_START;
            start_ev_reg <= mst_reg == M_START;
            inh_reg <= slave_inhibit;
            pre_reg <= 1'b1;
            addr_phase_reg <= 1'b1;
            slot_reg <= ACK_SLOT;
            sda_low_reg <= 1'b0;
        end else if (tx_take) begin
            shift_reg <= tx_data;
            need_tx_reg <= 1'b0;
            sda_low_reg <= !tx_data[7];
        end else if (ack_take) begin
            need_ack_reg <= 1'b0;
            ack_bit_reg <= sw_ack_value;
            sda_low_reg <= sw_ack_value;
        end else if (rise && slot_reg < ACK_SLOT) begin
            shift_reg <= byte_in;
            if (lost_c) begin
                master_reg <= 1'b0;
                slave_act_reg <= addr_phase_reg;
                lost_ev_reg <= 1'b1;
            end
            if (slot_reg == LAST_BIT && addr_phase_reg) begin
                addr_reg <= byte_in;
                dir_reg <= byte_in[0];
                ack_bit_reg <= hw_ack_enable && match;
                if (!is_mst && (inh_reg || (hw_ack_enable && !match))) begin
                    slave_act_reg <= 1'b0;
                end else if (!is_mst && !hw_ack_enable) begin
                    need_ack_reg <= 1'b1;
                    byte_ev_reg <= 1'b1;
                end
            end else if (slot_reg == LAST_BIT && !tx_mode) begin
                rx_byte_reg <= byte_in;
                push_pend_reg <= 1'b1;
                ack_bit_reg <= hw_ack_enable && !(master_reg && stop_pend_reg);
                need_ack_reg <= !hw_ack_enable;
                byte_ev_reg <= !hw_ack_enable;
            end
        end else if (rise) begin
            if (tx_mode) begin
                got_ack_reg <= !mon_if.sda;
            end
            byte_ev_reg <= tx_mode || hw_ack_enable;
        end else if (fall && pre_reg) begin
            pre_reg <= 1'b0;
            slot_reg <= 4'h0;
            need_tx_reg <= master_reg;
        end else if (fall && slot_reg == ACK_SLOT) begin
            slot_reg <= 4'h0;
            addr_phase_reg <= 1'b0;
            sda_low_reg <= 1'b0;
            if (master_reg && (stop_pend_reg || (tx_mode && !got_ack_reg))) begin
                stop_go_reg <= 1'b1;
            end else if (tx_mode && !got_ack_reg) begin
                slave_act_reg <= 1'b0;
            end else if (!tx_mode && !master_reg && !ack_bit_reg) begin
                slave_act_reg <= 1'b0;
            end else begin
                need_tx_reg <= master_reg ^ dir_reg;
            end
        end else if (fall) begin
            slot_reg <= slot_reg + 4'h1;
            if (slot_reg == LAST_BIT) begin
                sda_low_reg <= !tx_mode && ack_bit_reg && !need_ack_reg;
            end else begin
                sda_low_reg <= tx_mode && !shift_reg[7];
            end
        end
        if (rst) begin
            push_pend_reg <= 1'b0;
        end else if (push_pend_reg && fifo_ready) begin
            push_pend_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // requests and pins
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst || !enable) begin
            start_pend_reg <= 1'b0;
            stop_pend_reg <= 1'b0;
            scl_pin_low_reg <= 1'b0;
            sda_pin_low_reg <= 1'b0;
        end else begin
            if (mon_if.start_det && mst_reg == M_START) begin
                start_pend_reg <= 1'b0;
            end
            if (start_req) begin
                start_pend_reg <= 1'b1;
            end
            if (mon_if.stop_det) begin
                stop_pend_reg <= 1'b0;
            end
            if (stop_req) begin
                stop_pend_reg <= 1'b1;
            end
            scl_pin_low_reg <= mst_reg == M_LOW
                || (hold && !mon_if.scl && !master_reg);
            sda_pin_low_reg <= sda_force || sda_low_reg;
        end
    end

    smi_busmon #(
        .LOW_TO_CYC(LOW_TO_CYC)
    ) u_mon (
        .mclk(mclk),
        .rst(rst),
        .scl_pin(scl_in),
        .sda_pin(sda_in),
        .timer_ovf(timer_ovf),
        .bit_clock_source_select(bit_clock_source_select),
        .bus_free_timeout_enable(bus_free_timeout_enable),
        .scl_low_timeout_enable(scl_low_timeout_enable),
        .scl_timer_reload(scl_timer_reload),
        .mon(mon_if.mon)
    );
    assign scl_low_timeout = mon_if.low_timeout;

    smi_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(RX_DEPTH)
    ) u_rxq (
        .mclk(mclk),
        .rst(rst),
        .in_valid(push_pend_reg),
        .in_data(rx_byte_reg),
        .in_ready(fifo_ready),
        .out_valid(rx_valid),
        .out_data(rx_data),
        .out_ready(rx_ready)
    );
endmodule

//--- shared/smi_pkg.sv
// Purpose: constants and types shared by the two-wire serial interface
// Assumes: system clock of 125 MHz
// Notes: counts are derived from times in their own units
package smi_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int SCL_LOW_TIMEOUT_MS = 25;
    localparam int LOW_TIMEOUT_CYC =
        (SCL_LOW_TIMEOUT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYSCLK_PER_BIT = 20;
    localparam logic [3:0] MIN_HALF_CYC = 4'(SYSCLK_PER_BIT / 2);
    localparam logic [1:0] LOW_TICKS = 2'h1;
    localparam logic [1:0] HIGH_TICKS = 2'h2;
    localparam logic [3:0] FREE_TICKS = 4'hA;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [1:0] SRC_T0 = 2'h0;
    localparam logic [1:0] SRC_T1 = 2'h1;
    localparam logic [1:0] SRC_T2H = 2'h2;
    localparam logic [1:0] SYNC_IDLE = 2'h3;
    localparam int DATA_W = 8;
    localparam int RX_DEPTH = 32;
    typedef enum logic [2:0] {
        M_IDLE = 3'b000,
        M_START = 3'b001,
        M_LOW = 3'b010,
        M_RISE = 3'b011,
        M_HIGH = 3'b100,
        M_STOP = 3'b101,
        M_STOPH = 3'b110
    } smi_mst_e;
endpackage

//--- shared/smi_mon_if.sv
// Purpose: bus observation signals from the line monitor to the byte engine
// Assumes: all signals on mclk
// Notes: edges and conditions are one-cycle pulses
`timescale 1ns/10ps
interface smi_mon_if;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic tick;
    logic bus_free;
    logic low_timeout;
    modport mon (output scl, sda, scl_rise, scl_fall, start_det, stop_det, tick,
        bus_free, low_timeout);
    modport eng (input scl, sda, scl_rise, scl_fall, start_det, stop_det, tick,
        bus_free, low_timeout);
endinterface

//--- src/smi_fifo.sv
// Purpose: receive byte queue with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: in_ready low stalls the byte engine, which stretches SCL
`timescale 1ns/10ps
module smi_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    logic push;
    logic pop;

    assign in_ready = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
    assign out_valid = wr_ptr_reg != rd_ptr_reg;
    assign out_data = mem[rd_ptr_reg[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end
endmodule

//--- src/smi_busmon.sv
// Purpose: line synchronisers, START/STOP detection, free and low timeouts
// Assumes: timer overflow inputs are one-cycle pulses on mclk
// Notes: bus is taken as busy from reset until STOP or free timeout
`timescale 1ns/10ps
module smi_busmon #(
    parameter int LOW_TO_CYC = smi_pkg::LOW_TIMEOUT_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic scl_pin,
    input wire logic sda_pin,
    input wire logic [3:0] timer_ovf,
    input wire logic [1:0] bit_clock_source_select,
    input wire logic bus_free_timeout_enable,
    input wire logic scl_low_timeout_enable,
    output logic scl_timer_reload,
    smi_mon_if.mon mon
);
    import smi_pkg::*;
    localparam int LW = $clog2(LOW_TO_CYC + 1);
    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic scl_q_reg;
    logic sda_q_reg;
    logic busy_reg;
    logic to_reg;
    logic reload_reg;
    logic [3:0] free_cnt_reg;
    logic [LW-1:0] low_cnt_reg;
    logic both_high;
    logic free_hit;

    assign mon.scl = scl_sync_reg[1];
    assign mon.sda = sda_sync_reg[1];
    assign mon.scl_rise = scl_sync_reg[1] && !scl_q_reg;
    assign mon.scl_fall = !scl_sync_reg[1] && scl_q_reg;
    assign mon.start_det = scl_q_reg && scl_sync_reg[1] && sda_q_reg && !sda_sync_reg[1];
    assign mon.stop_det = scl_q_reg && scl_sync_reg[1] && !sda_q_reg && sda_sync_reg[1];
    assign mon.tick = (bit_clock_source_select == SRC_T0) ? timer_ovf[0] :
        (bit_clock_source_select == SRC_T1) ? timer_ovf[1] :
        (bit_clock_source_select == SRC_T2H) ? timer_ovf[2] : timer_ovf[3];
    assign mon.bus_free = !busy_reg;
    assign mon.low_timeout = to_reg;
    assign scl_timer_reload = reload_reg;
    assign both_high = scl_sync_reg[1] && sda_sync_reg[1];
    assign free_hit = free_cnt_reg > FREE_TICKS;

    always_ff @(posedge mclk) begin
        if (rst) begin
            scl_sync_reg <= SYNC_IDLE;
            sda_sync_reg <= SYNC_IDLE;
            scl_q_reg <= 1'b1;
            sda_q_reg <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], scl_pin};
            sda_sync_reg <= {sda_sync_reg[0], sda_pin};
            scl_q_reg <= scl_sync_reg[1];
            sda_q_reg <= sda_sync_reg[1];
        end
    end

    // ----------------------------------------------------------------
    // free timeout, runs whether master or slave
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst || !both_high) begin
            free_cnt_reg <= 4'h0;
        end else if (mon.tick && !free_hit) begin
            free_cnt_reg <= free_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            busy_reg <= 1'b1;
        end else if (mon.start_det) begin
            busy_reg <= 1'b1;
        end else if (mon.stop_det || (bus_free_timeout_enable && free_hit)) begin
            busy_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // scl low timeout: reload while high, count while low
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst || !scl_low_timeout_enable || scl_sync_reg[1]) begin
            low_cnt_reg <= '0;
        end else if (low_cnt_reg != LW'(LOW_TO_CYC)) begin
            low_cnt_reg <= low_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            to_reg <= 1'b0;
            reload_reg <= 1'b0;
        end else begin
            to_reg <= scl_low_timeout_enable && !scl_sync_reg[1]
                && low_cnt_reg == LW'(LOW_TO_CYC - 1);
            reload_reg <= scl_low_timeout_enable && scl_sync_reg[1];
        end
    end
endmodule

//--- tb/smi_props.sv
// Purpose: timing checks on the top ports
// Assumes: one clock domain on mclk
// Notes: bound to every smi_top
`timescale 1ns/10ps
module smi_props
import smi_pkg::*;
#(parameter int LOW_TO_CYC = 200) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic scl_oe_n,
    input wire logic sda_oe_n,
    input wire logic [3:0] timer_ovf,
    input wire logic [1:0] bit_clock_source_select,
    input wire logic scl_low_timeout_enable,
    input wire logic scl_timer_reload,
    input wire logic bus_busy,
    input wire logic stop_event,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic [smi_pkg::DATA_W-1:0] rx_data
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    int lowc = 0;
    int highc = 0;
    int hic = 0;
    // phase lengths and selected ticks while both lines are high
    always_ff @(posedge mclk) begin
        lowc <= scl_oe_n ? 0 : lowc + 1;
        highc <= scl_in ? highc + 1 : 0;
        hic <= (rst || !scl_in || !sda_in) ? 0 : hic + int'(timer_ovf[bit_clock_source_select]);
    end
    property p_low; $rose(scl_oe_n) |-> lowc >= MIN_HALF_CYC; endproperty
    a_low: assert property (p_low) else $error("scl low phase short");
    property p_high; $fell(scl_oe_n) |-> highc >= MIN_HALF_CYC; endproperty
    a_high: assert property (p_high) else $error("scl high phase short");
    property p_reload;
        $stable({scl_low_timeout_enable, scl_in}) [*5] |->
            scl_timer_reload == (scl_low_timeout_enable && scl_in);
    endproperty
    a_reload: assert property (p_reload) else $error("timer reload wrong");
    property p_busy; $fell(sda_oe_n) && scl_oe_n && scl_in |-> !$past(bus_busy); endproperty
    a_busy: assert property (p_busy) else $error("start on busy bus");
    property p_start; $fell(sda_in) && scl_in |-> ##[1:6] bus_busy; endproperty
    a_start: assert property (p_start) else $error("start not seen");
    property p_stop; $rose(sda_in) && scl_in |-> ##[1:6] stop_event; endproperty
    a_stop: assert property (p_stop) else $error("stop not seen");
    property p_free; $fell(bus_busy) |-> hic >= FREE_TICKS || !$past(sda_in, 8); endproperty
    a_free: assert property (p_free) else $error("bus freed early");
    property p_rx; rx_valid && !rx_ready |=> rx_valid && $stable(rx_data); endproperty
    a_rx: assert property (p_rx) else $error("rx byte lost");
    c_stop: cover property (stop_event);
    c_pop: cover property (rx_valid && rx_ready);
    c_free: cover property ($fell(bus_busy));
endmodule
bind smi_top smi_props #(.LOW_TO_CYC(LOW_TO_CYC)) smi_props_i (.*);

//--- tb/smi_peer.sv
// Purpose: slave device on the shared two-wire bus
// Assumes: pull-ups on both lines in the bench
// Notes: acks its address and written bytes, sends its fixed byte for every byte read until nacked
`timescale 1ns/10ps
module smi_peer #(
    parameter logic [6:0] ADDR = 7'h5A,
    parameter logic [7:0] RD_BYTE = 8'hA5
) (
    input wire logic scl,
    input wire logic sda,
    output logic sda_low
);
    logic [7:0] got [$];
    logic [7:0] sh = 8'h00;
    initial sda_low = 1'b0;
    task automatic get_byte();
        repeat (8) begin
            @(posedge scl);
            sh = {sh[6:0], sda};
        end
        got.push_back(sh);
    endtask
    task automatic ack();
        @(negedge scl) sda_low = 1'b1;
        @(negedge scl) sda_low = 1'b0;
    endtask
    task automatic xfer();
        logic rd;
        get_byte();
        rd = sh[0];
        if (sh[7:1] != ADDR) return;
        ack();
        forever begin
            if (rd) begin
                for (int i = 7; i >= 0; i--) begin
                    sda_low = !RD_BYTE[i];
                    @(negedge scl);
                end
                sda_low = 1'b0;
                @(posedge scl);
                if (sda) return;
                @(negedge scl);
            end else begin
                get_byte();
                ack();
            end
        end
    endtask
    always begin
        @(negedge sda iff scl === 1'b1);
        fork
            xfer();
            @(posedge sda iff scl === 1'b1);
        join_any
        disable fork;
        sda_low = 1'b0;
    end
endmodule

//--- tb/smi_top_bench.sv
// Purpose: self-checking bench for the two-wire master
// Assumes: ticks every fourth mclk on the selected source only
// Notes: the peer model is the addressed slave
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
    $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
`define WAITC(c) for (wt = 0; !(c); wt++) begin if (wt > 4000) begin err_total++; \
    finish_test(); end step(); end
module smi_top_bench;
    import smi_pkg::*;
    logic mclk = 1'b0, rst = 1'b1, enable = 1'b1, slave_inhibit = 1'b0, hw_ack_enable = 1'b1;
    logic scl_low_timeout_enable = 1'b1, bus_free_timeout_enable = 1'b1;
    logic start_req = 1'b0, stop_req = 1'b0, tx_valid = 1'b0, rx_ready = 1'b0;
    logic sw_ack_valid = 1'b0, sw_ack_value = 1'b1;
    logic [1:0] bit_clock_source_select = 2'h0;
    logic [3:0] timer_ovf = 4'h0;
    logic [6:0] own_addr = 7'h11;
    logic [7:0] tx_data = 8'h00;
    logic scl_out, scl_oe_n, sda_out, sda_oe_n, tx_ready, rx_valid, byte_event, start_event;
    logic stop_event, arb_lost, got_ack, is_master, is_slave, bus_busy;
    logic scl_timer_reload, scl_low_timeout;
    logic [7:0] rx_data, addr_byte;
    int err_total = 0, checks_done = 0, wt = 0, tcnt = 0;
    wire logic peer_low;
    wire logic scl_in = scl_oe_n !== 1'b0;
    wire logic sda_in = sda_oe_n !== 1'b0 && !peer_low;
    smi_top #(.LOW_TO_CYC(200)) smi_top_i (.*);
    smi_peer #(.ADDR(7'h5A), .RD_BYTE(8'hA5)) smi_peer_i (.scl(scl_in), .sda(sda_in),
        .sda_low(peer_low));
    always #4 mclk = ~mclk;
    always @(posedge mclk) begin
        tcnt <= tcnt + 1;
        timer_ovf <= #1 (tcnt % 4 == 0) ? 4'h1 << bit_clock_source_select : 4'h0;
    end
    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic step();
        @(posedge mclk);
        #1;
    endtask
    task automatic send(input logic [7:0] b, input logic last);
        `WAITC(tx_ready === 1'b1)
        tx_data = b;
        tx_valid = 1'b1;
        step();
        tx_valid = 1'b0;
        stop_req = last;
        step();
        stop_req = 1'b0;
    endtask
    task automatic xact(input logic [7:0] a, input logic [7:0] d, input logic ack_exp);
        smi_peer_i.got.delete();
        start_req = 1'b1;
        step();
        start_req = 1'b0;
        `WAITC(start_event === 1'b1)
        `CHK(is_master, 1'b1)
        send(a, !ack_exp);
        if (!a[0] && ack_exp) send(d, 1'b1);
        if (a[0]) begin
            `WAITC(byte_event === 1'b1)
            `WAITC(scl_oe_n === 1'b0)
            repeat (4) step();
            stop_req = 1'b1;
            step();
            stop_req = 1'b0;
        end
        `WAITC(stop_event === 1'b1)
        `CHK(is_master, 1'b0)
        `CHK(addr_byte, a)
        `CHK(got_ack, ack_exp)
        `CHK(smi_peer_i.got[0], a)
        if (!a[0] && ack_exp) `CHK(smi_peer_i.got[1], d)
    endtask
    task automatic t_reset();
        `CHK(bus_busy, 1'b1)
        `CHK(sda_oe_n, 1'b1)
        repeat (20) step();
        `CHK(bus_busy, 1'b1)
        `CHK(scl_timer_reload, 1'b1)
    endtask
    task automatic t_write();
        for (int s = 0; s < 4; s++) begin
            bit_clock_source_select = 2'(s);
            xact(8'hB4, 8'h3C + 8'(s), 1'b1);
        end
    endtask
    task automatic t_read();
        xact(8'hB5, 8'h00, 1'b1);
        `CHK(rx_valid, 1'b1)
        `CHK(rx_data, 8'hA5)
        rx_ready = 1'b1;
        step();
        rx_ready = 1'b0;
        `CHK(rx_valid, 1'b0)
    endtask
    task automatic t_timeout();
        start_req = 1'b1;
        step();
        start_req = 1'b0;
        `WAITC(tx_ready === 1'b1)
        `WAITC(scl_low_timeout === 1'b1)
        repeat (2) step();
        `CHK(is_master, 1'b0)
        `CHK(scl_oe_n, 1'b1)
    endtask
    task automatic t_reload();
        scl_low_timeout_enable = 1'b0;
        repeat (6) step();
        `CHK(scl_timer_reload, 1'b0)
    endtask
    initial begin
        repeat (12) step();
        rst = 1'b0;
        t_reset();
        t_write();
        xact(8'h24, 8'h00, 1'b0);
        t_read();
        t_timeout();
        t_reload();
        finish_test();
    end
endmodule
